// ### rtl/cis_pkg.sv
package cis_pkg;

	// opcodes decoded by the sequencer
	localparam logic [7:0] OP_LDA_IMM = 8'hA6;
	localparam logic [7:0] OP_STA_DIR = 8'hB7;
	localparam logic [7:0] OP_JSR_EXT = 8'hCD;
	localparam logic [7:0] OP_BSR     = 8'hAD;
	localparam logic [7:0] OP_RTS     = 8'h81;
	localparam logic [7:0] OP_DECREMENT_ACCUMULATOR    = 8'h4A;
	localparam logic [7:0] OP_BRA     = 8'h20;
	localparam logic [7:0] OP_BNE     = 8'h26;
	localparam logic [7:0] OP_BEQ     = 8'h27;
	localparam logic [7:0] OP_BPL     = 8'h2A;
	localparam logic [7:0] OP_BMI     = 8'h2B;

	// opcode high nibbles of the two branch families
	localparam logic [3:0] REL_NIBBLE = 4'h2;
	localparam logic [3:0] BT_NIBBLE  = 4'h0;

	// address and reset constants
	localparam logic [7:0]  PAGE_ZERO = 8'h00;
	localparam logic [7:0]  SP_RESET  = 8'hFF;
	localparam logic [7:0]  BYTE_ONE  = 8'h01;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [15:0] PC_RESET  = 16'h0000;
	localparam logic [15:0] PC_STEP   = 16'h0001;
	localparam int          SIGN_BIT  = 7;

	// gray order along the common paths
	typedef enum logic [4:0] {
		S_FETCH      = 5'h00,
		S_LDA        = 5'h01,
		S_STA_DIR    = 5'h03,
		S_STA_BUILD  = 5'h02,
		S_STA_WRITE  = 5'h06,
		S_BR_OFF     = 5'h07,
		S_BR_EXEC    = 5'h05,
		S_BT_DIR     = 5'h04,
		S_BT_READ    = 5'h0C,
		S_BT_OFF     = 5'h0D,
		S_DEC_CALC   = 5'h0F,
		S_DEC_IDLE   = 5'h0E,
		S_JSR_HI     = 5'h0A,
		S_JSR_LO     = 5'h0B,
		S_BSR_OFF    = 5'h09,
		S_CALL_BUILD = 5'h08,
		S_PUSH_LO    = 5'h18,
		S_PUSH_HI    = 5'h19,
		S_RTS_INC    = 5'h1B,
		S_RTS_RDHI   = 5'h1A,
		S_RTS_RDLO   = 5'h1E,
		S_RTS_LOAD   = 5'h1F,
		S_RTS_END    = 5'h1D
	} cis_state_e;

endpackage

// ### rtl/cis_flag_if.sv
`timescale 1ns/100ps
interface cis_flag_if;
	logic       ld;
	logic [7:0] val;
	logic       n;
	logic       z;

	modport core (output ld, output val, input n, input z);
	modport unit (input ld, input val, output n, output z);
endinterface

// ### rtl/cis_flags.sv
`timescale 1ns/100ps
module cis_flags (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// value written to the accumulator
	cis_flag_if.unit  fl
);
	logic flag_n_ff;
	logic flag_z_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag_n_ff <= 1'b0;
			flag_z_ff <= 1'b0;
		end else if (fl.ld) begin
			flag_n_ff <= fl.val[cis_pkg::SIGN_BIT]; // RULE6
			flag_z_ff <= (fl.val == cis_pkg::BYTE_ZERO); // RULE5
		end
	end

	assign fl.n = flag_n_ff;
	assign fl.z = flag_z_ff;
endmodule

// ### rtl/cis_sequencer.sv
// Summary of operation
// RULE1 - A direct store forms its address from a zero high byte and the operand byte.
// RULE2 - In its fourth cycle a direct store drives that address, the accumulator and the write strobe.
// RULE3 - The immediate accumulator load takes exactly two cycles.
// RULE4 - Load cycle one fetches the opcode and steps the program counter, cycle two takes the data byte and steps it again.
// RULE5 - Loading the accumulator sets zero exactly when the value is zero.
// RULE6 - Loading the accumulator copies bit seven of the value into negative.
// RULE7 - Ordinary conditional branches are an opcode and one offset byte.
// RULE8 - Bit-test branches are an opcode, a direct address and an offset byte.
// RULE9 - A true branch adds the signed offset to the program counter, a false one falls through.
// RULE10 - Branch if plus is taken while negative is clear.
// RULE11 - Branch if bit clear reads the direct byte and branches when the chosen bit is zero.
// RULE12 - Calls move control to the subroutine and return resumes after the call.
// RULE13 - A call writes the return low byte at the stack pointer, decrements, writes the high byte, decrements.
// RULE14 - The extended call fetches high then low address byte and builds the target before pushing.
// RULE15 - Return takes six cycles: increment, read high, increment, read low, load program counter.
// RULE16 - The branch offset is added to a program counter already past the whole branch.
`timescale 1ns/100ps
module cis_sequencer (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// internal memory bus
	input  wire logic [7:0]  mem_rdata,
	output logic      [15:0] mem_addr,
	output logic      [7:0]  mem_wdata,
	output logic             mem_we,
	// processor state
	output logic             opcode_fetch,
	output logic      [15:0] prog_counter,
	output logic      [7:0]  accumulator,
	output logic      [7:0]  stack_pointer,
	output logic             flag_n,
	output logic             flag_z
);
	cis_pkg::cis_state_e state_ff, nxt_state;
	logic [15:0] pc_ff, nxt_pc;
	logic [15:0] addr_ff, nxt_addr;
	logic [15:0] tgt_ff, nxt_tgt;
	logic [7:0]  acc_ff, nxt_acc;
	logic [7:0]  sp_ff, nxt_sp;
	logic [7:0]  op_ff, nxt_op;
	logic [7:0]  hi_ff, nxt_hi;
	logic [7:0]  lo_ff, nxt_lo;
	logic [7:0]  off_ff, nxt_off;
	logic [7:0]  wdata_ff, nxt_wdata;
	logic        we_ff, nxt_we;
	logic        tbit_ff, nxt_tbit;
	logic        fetch_ff;
	logic        flag_ld;
	logic [7:0]  flag_val;

	cis_flag_if fl ();

	cis_flags u_flags (
		.clk_sys (clk_sys),
		.rst     (rst),
		.fl      (fl.unit)
	);

	assign fl.ld  = flag_ld;
	assign fl.val = flag_val;

	// arithmetic and decode
	wire [15:0] pc_inc   = pc_ff + cis_pkg::PC_STEP;
	wire [15:0] off_ext  = 16'(signed'(off_ff));
	wire [15:0] br_tgt   = pc_ff + off_ext;
	wire [15:0] zp_sp    = {cis_pkg::PAGE_ZERO, sp_ff};
	wire [7:0]  sp_inc   = sp_ff + cis_pkg::BYTE_ONE;
	wire [7:0]  sp_dec   = sp_ff - cis_pkg::BYTE_ONE;
	wire [7:0]  acc_dec  = acc_ff - cis_pkg::BYTE_ONE;
	wire        f_rel    = mem_rdata[7:4] == cis_pkg::REL_NIBBLE;
	wire        f_bt     = mem_rdata[7:4] == cis_pkg::BT_NIBBLE;
	wire        is_bt    = op_ff[7:4] == cis_pkg::BT_NIBBLE;
	wire        is_bsr   = op_ff == cis_pkg::OP_BSR;
	wire        rel_cond = (op_ff == cis_pkg::OP_BRA)
		| ((op_ff == cis_pkg::OP_BNE) & ~fl.z)
		| ((op_ff == cis_pkg::OP_BEQ) & fl.z)
		| ((op_ff == cis_pkg::OP_BPL) & ~fl.n) // RULE10
		| ((op_ff == cis_pkg::OP_BMI) & fl.n);
	// low opcode bit picks the clear form of a bit test
	wire        bt_cond  = op_ff[0] ? ~tbit_ff : tbit_ff; // RULE11
	wire        br_take  = is_bt ? bt_cond : rel_cond;
	wire        sel_bit  = mem_rdata[op_ff[3:1]];

	always_comb begin
		nxt_state = state_ff;
		nxt_pc    = pc_ff;
		nxt_addr  = addr_ff;
		nxt_tgt   = tgt_ff;
		nxt_acc   = acc_ff;
		nxt_sp    = sp_ff;
		nxt_op    = op_ff;
		nxt_hi    = hi_ff;
		nxt_lo    = lo_ff;
		nxt_off   = off_ff;
		nxt_wdata = wdata_ff;
		nxt_tbit  = tbit_ff;
		nxt_we    = 1'b0;
		flag_ld   = 1'b0;
		flag_val  = mem_rdata;
		unique case (state_ff)
			cis_pkg::S_FETCH: begin
				nxt_op   = mem_rdata;
				nxt_pc   = pc_inc; // RULE4
				nxt_addr = pc_inc;
				if (mem_rdata == cis_pkg::OP_LDA_IMM) begin
					nxt_state = cis_pkg::S_LDA; // RULE3
				end else if (mem_rdata == cis_pkg::OP_STA_DIR) begin
					nxt_state = cis_pkg::S_STA_DIR;
				end else if (f_rel) begin
					nxt_state = cis_pkg::S_BR_OFF; // RULE7
				end else if (f_bt) begin
					nxt_state = cis_pkg::S_BT_DIR; // RULE8
				end else if (mem_rdata == cis_pkg::OP_DECREMENT_ACCUMULATOR) begin
					nxt_state = cis_pkg::S_DEC_CALC;
				end else if (mem_rdata == cis_pkg::OP_JSR_EXT) begin
					nxt_state = cis_pkg::S_JSR_HI;
				end else if (mem_rdata == cis_pkg::OP_BSR) begin
					nxt_state = cis_pkg::S_BSR_OFF;
				end else if (mem_rdata == cis_pkg::OP_RTS) begin
					nxt_state = cis_pkg::S_RTS_INC;
				end else begin
					nxt_state = cis_pkg::S_FETCH;
				end
			end
			cis_pkg::S_LDA: begin
				nxt_acc   = mem_rdata; // RULE4
				flag_ld   = 1'b1; // RULE5
				nxt_pc    = pc_inc;
				nxt_addr  = pc_inc;
				nxt_state = cis_pkg::S_FETCH; // RULE3
			end
			cis_pkg::S_STA_DIR: begin
				nxt_lo    = mem_rdata;
				nxt_state = cis_pkg::S_STA_BUILD;
			end
			cis_pkg::S_STA_BUILD: begin
				nxt_pc    = pc_inc;
				nxt_addr  = {cis_pkg::PAGE_ZERO, lo_ff}; // RULE1
				nxt_wdata = acc_ff; // RULE2
				nxt_we    = 1'b1;
				nxt_state = cis_pkg::S_STA_WRITE;
			end
			cis_pkg::S_STA_WRITE: begin
				nxt_addr  = pc_ff;
				nxt_state = cis_pkg::S_FETCH;
			end
			cis_pkg::S_BR_OFF, cis_pkg::S_BT_OFF: begin
				nxt_off   = mem_rdata;
				nxt_pc    = pc_inc;
				nxt_addr  = pc_inc;
				nxt_state = cis_pkg::S_BR_EXEC;
			end
			cis_pkg::S_BR_EXEC: begin
				// pc already points past the branch here
				nxt_pc    = br_take ? br_tgt : pc_ff; // RULE9 RULE16
				nxt_addr  = br_take ? br_tgt : pc_ff;
				nxt_state = cis_pkg::S_FETCH;
			end
			cis_pkg::S_BT_DIR: begin
				nxt_lo    = mem_rdata;
				nxt_pc    = pc_inc;
				nxt_addr  = {cis_pkg::PAGE_ZERO, mem_rdata}; // RULE11
				nxt_state = cis_pkg::S_BT_READ;
			end
			cis_pkg::S_BT_READ: begin
				nxt_tbit  = sel_bit;
				nxt_addr  = pc_ff;
				nxt_state = cis_pkg::S_BT_OFF;
			end
			cis_pkg::S_DEC_CALC: begin
				nxt_acc   = acc_dec;
				flag_val  = acc_dec;
				flag_ld   = 1'b1;
				nxt_state = cis_pkg::S_DEC_IDLE;
			end
			cis_pkg::S_DEC_IDLE: begin
				nxt_addr  = pc_ff;
				nxt_state = cis_pkg::S_FETCH;
			end
			cis_pkg::S_JSR_HI: begin
				nxt_hi    = mem_rdata; // RULE14
				nxt_pc    = pc_inc;
				nxt_addr  = pc_inc;
				nxt_state = cis_pkg::S_JSR_LO;
			end
			cis_pkg::S_JSR_LO: begin
				nxt_lo    = mem_rdata; // RULE14
				nxt_pc    = pc_inc;
				nxt_state = cis_pkg::S_CALL_BUILD;
			end
			cis_pkg::S_BSR_OFF: begin
				nxt_off   = mem_rdata;
				nxt_pc    = pc_inc;
				nxt_state = cis_pkg::S_CALL_BUILD;
			end
			cis_pkg::S_CALL_BUILD: begin
				nxt_tgt   = is_bsr ? br_tgt : {hi_ff, lo_ff}; // RULE14
				nxt_addr  = zp_sp; // RULE13
				nxt_wdata = pc_ff[7:0];
				nxt_we    = 1'b1;
				nxt_state = cis_pkg::S_PUSH_LO;
			end
			cis_pkg::S_PUSH_LO: begin
				nxt_sp    = sp_dec; // RULE13
				nxt_addr  = {cis_pkg::PAGE_ZERO, sp_dec};
				nxt_wdata = pc_ff[15:8];
				nxt_we    = 1'b1;
				nxt_state = cis_pkg::S_PUSH_HI;
			end
			cis_pkg::S_PUSH_HI: begin
				nxt_sp    = sp_dec; // RULE13
				nxt_pc    = tgt_ff; // RULE12
				nxt_addr  = tgt_ff;
				nxt_state = cis_pkg::S_FETCH;
			end
			cis_pkg::S_RTS_INC: begin
				nxt_sp    = sp_inc; // RULE15
				nxt_addr  = {cis_pkg::PAGE_ZERO, sp_inc};
				nxt_state = cis_pkg::S_RTS_RDHI;
			end
			cis_pkg::S_RTS_RDHI: begin
				nxt_hi    = mem_rdata; // RULE15
				nxt_sp    = sp_inc;
				nxt_addr  = {cis_pkg::PAGE_ZERO, sp_inc};
				nxt_state = cis_pkg::S_RTS_RDLO;
			end
			cis_pkg::S_RTS_RDLO: begin
				nxt_lo    = mem_rdata;
				nxt_state = cis_pkg::S_RTS_LOAD;
			end
			cis_pkg::S_RTS_LOAD: begin
				nxt_pc    = {hi_ff, lo_ff}; // RULE12 RULE15
				nxt_state = cis_pkg::S_RTS_END;
			end
			cis_pkg::S_RTS_END: begin
				nxt_addr  = pc_ff;
				nxt_state = cis_pkg::S_FETCH;
			end
			default: begin
				// illegal code: resynchronise on the current pc
				nxt_addr  = pc_ff;
				nxt_state = cis_pkg::S_FETCH;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= cis_pkg::S_FETCH;
			pc_ff    <= cis_pkg::PC_RESET;
			addr_ff  <= cis_pkg::PC_RESET;
			tgt_ff   <= cis_pkg::PC_RESET;
			acc_ff   <= cis_pkg::BYTE_ZERO;
			sp_ff    <= cis_pkg::SP_RESET;
			op_ff    <= cis_pkg::BYTE_ZERO;
			hi_ff    <= cis_pkg::BYTE_ZERO;
			lo_ff    <= cis_pkg::BYTE_ZERO;
			off_ff   <= cis_pkg::BYTE_ZERO;
			wdata_ff <= cis_pkg::BYTE_ZERO;
			we_ff    <= 1'b0;
			tbit_ff  <= 1'b0;
			fetch_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			pc_ff    <= nxt_pc;
			addr_ff  <= nxt_addr;
			tgt_ff   <= nxt_tgt;
			acc_ff   <= nxt_acc;
			sp_ff    <= nxt_sp;
			op_ff    <= nxt_op;
			hi_ff    <= nxt_hi;
			lo_ff    <= nxt_lo;
			off_ff   <= nxt_off;
			wdata_ff <= nxt_wdata;
			we_ff    <= nxt_we;
			tbit_ff  <= nxt_tbit;
			fetch_ff <= (nxt_state == cis_pkg::S_FETCH);
		end
	end

	assign mem_addr      = addr_ff;
	assign mem_wdata     = wdata_ff;
	assign mem_we        = we_ff;
	assign opcode_fetch  = fetch_ff;
	assign prog_counter  = pc_ff;
	assign accumulator   = acc_ff;
	assign stack_pointer = sp_ff;
	assign flag_n        = fl.n;
	assign flag_z        = fl.z;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_sta_addr;
		state_ff == cis_pkg::S_STA_WRITE |->
			addr_ff == {cis_pkg::PAGE_ZERO, $past(mem_rdata, 2)};
	endproperty
	a_sta_addr: assert property (p_sta_addr) // RULE1
		else $error("direct store address wrong");

	property p_sta_write;
		state_ff == cis_pkg::S_STA_BUILD |=>
			(we_ff && wdata_ff == $past(acc_ff)) ##1 !we_ff;
	endproperty
	a_sta_write: assert property (p_sta_write) // RULE2
		else $error("direct store write cycle wrong");

	property p_lda_two;
		(state_ff == cis_pkg::S_FETCH && mem_rdata == cis_pkg::OP_LDA_IMM)
			|=> state_ff == cis_pkg::S_LDA ##1 state_ff == cis_pkg::S_FETCH;
	endproperty
	a_lda_two: assert property (p_lda_two) // RULE3
		else $error("immediate load not two cycles");

	property p_lda_pc;
		state_ff == cis_pkg::S_LDA |=> acc_ff == $past(mem_rdata)
			&& pc_ff == $past(pc_ff) + cis_pkg::PC_STEP && addr_ff == pc_ff;
	endproperty
	a_lda_pc: assert property (p_lda_pc) // RULE4
		else $error("immediate load data or pc wrong");

	property p_flag_z;
		state_ff == cis_pkg::S_LDA |=>
			fl.z == ($past(mem_rdata) == cis_pkg::BYTE_ZERO);
	endproperty
	a_flag_z: assert property (p_flag_z) // RULE5
		else $error("zero flag wrong after load");

	property p_flag_n;
		state_ff == cis_pkg::S_LDA |=>
			fl.n == $past(mem_rdata[cis_pkg::SIGN_BIT]);
	endproperty
	a_flag_n: assert property (p_flag_n) // RULE6
		else $error("negative flag wrong after load");

	property p_bt_len;
		(state_ff == cis_pkg::S_FETCH && f_bt) |=>
			state_ff == cis_pkg::S_BT_DIR ##1 state_ff == cis_pkg::S_BT_READ
			##1 state_ff == cis_pkg::S_BT_OFF ##1 state_ff == cis_pkg::S_BR_EXEC;
	endproperty
	a_bt_len: assert property (p_bt_len) // RULE8
		else $error("bit-test branch length wrong");

	property p_br_taken;
		(state_ff == cis_pkg::S_BR_EXEC && br_take) |=>
			pc_ff == $past(pc_ff) + $past(off_ext) && addr_ff == pc_ff;
	endproperty
	a_br_taken: assert property (p_br_taken) // RULE9 RULE16
		else $error("taken branch target wrong");

	property p_bpl;
		// judged on the resulting pc, not on the decode wire itself
		(state_ff == cis_pkg::S_BR_EXEC && op_ff == cis_pkg::OP_BPL)
			|=> pc_ff == ($past(fl.n) ? $past(pc_ff)
			: $past(pc_ff) + $past(off_ext));
	endproperty
	a_bpl: assert property (p_bpl) // RULE10
		else $error("branch if plus decision wrong");

	property p_push;
		state_ff == cis_pkg::S_CALL_BUILD |=>
			(we_ff && addr_ff == {cis_pkg::PAGE_ZERO, $past(sp_ff)}
			&& wdata_ff == $past(pc_ff[7:0]))
			##1 (we_ff && sp_ff == $past(sp_ff) - cis_pkg::BYTE_ONE
			&& wdata_ff == pc_ff[15:8]);
	endproperty
	a_push: assert property (p_push) // RULE13
		else $error("return address push wrong");

	property p_jsr;
		state_ff == cis_pkg::S_JSR_LO |-> ##4 (state_ff == cis_pkg::S_FETCH
			&& pc_ff == {hi_ff, $past(mem_rdata, 4)});
	endproperty
	a_jsr: assert property (p_jsr) // RULE14 RULE12
		else $error("extended call target wrong");

	property p_rts;
		(state_ff == cis_pkg::S_FETCH && mem_rdata == cis_pkg::OP_RTS) |->
			##6 (state_ff == cis_pkg::S_FETCH && pc_ff == {hi_ff, lo_ff}
			&& sp_ff == $past(sp_ff, 5) + 8'h02);
	endproperty
	a_rts: assert property (p_rts) // RULE15 RULE12
		else $error("return sequence wrong");

	c_sta: cover property (state_ff == cis_pkg::S_STA_WRITE && we_ff);
	c_taken: cover property (state_ff == cis_pkg::S_BR_EXEC && br_take);
	c_call: cover property (state_ff == cis_pkg::S_PUSH_HI);
	c_ret: cover property (state_ff == cis_pkg::S_RTS_END);
endmodule

// ### verif/cis_mem_model.sv
`timescale 1ns/100ps
module cis_mem_model (
	// clock
	input  wire logic        clk_sys,
	// internal memory bus
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_we,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] mem [0:65535];

	// zero wait state: the core samples the byte in the same cycle
	assign mem_rdata = mem[mem_addr];

	always @(posedge clk_sys) begin
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
		end
	end

	// filler differs from 00 so a missing write cannot pass unseen
	task clear;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'hEE;
		end
	endtask

	// n bytes of w, most significant first, from address a upwards
	task put(input logic [15:0] a, input logic [31:0] w, input int n);
		for (int k = 0; k < n; k++) begin
			mem[a + k[15:0]] = w[31 - 8 * k -: 8];
		end
	endtask
endmodule

// ### verif/tb_cpu_instruction_sequencer.sv
`timescale 1ns/100ps
module tb_cpu_instruction_sequencer;
	logic        clk_sys;
	logic        rst;
	logic [7:0]  mem_rdata;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic        mem_we;
	logic        opcode_fetch;
	logic [15:0] prog_counter;
	logic [7:0]  accumulator;
	logic [7:0]  stack_pointer;
	logic        flag_n;
	logic        flag_z;
	int          error_cnt;
	int          n_compared;

	cis_sequencer dut (
		.clk_sys       (clk_sys),
		.rst           (rst),
		.mem_rdata     (mem_rdata),
		.mem_addr      (mem_addr),
		.mem_wdata     (mem_wdata),
		.mem_we        (mem_we),
		.opcode_fetch  (opcode_fetch),
		.prog_counter  (prog_counter),
		.accumulator   (accumulator),
		.stack_pointer (stack_pointer),
		.flag_n        (flag_n),
		.flag_z        (flag_z)
	);

	cis_mem_model mem (
		.clk_sys   (clk_sys),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.mem_we    (mem_we),
		.mem_rdata (mem_rdata)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask

	// inputs move 1 ns after the edge, outputs are settled by then
	task step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task at_fetch(input int cyc, input logic [15:0] a);
		step(cyc);
		chk("opcode_fetch", 16'h0001, {15'h0000, opcode_fetch});
		chk("fetch address", a, mem_addr);
	endtask

	task start_reset;
		@(posedge clk_sys);
		#1;
		rst = 1'b1;
		mem.clear();
	endtask

	task release_reset(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		chk("reset fetch address", 16'h0000, mem_addr);
		chk("reset stack pointer", 16'h00FF, {8'h00, stack_pointer});
		chk("reset accumulator", 16'h0000, {8'h00, accumulator});
		chk("reset program counter", 16'h0000, prog_counter);
		chk("reset flags", 16'h0000, {14'h0000, flag_n, flag_z});
		chk("reset strobe", 16'h0000, {15'h0000, mem_we});
		chk("reset opcode_fetch", 16'h0001, {15'h0000, opcode_fetch});
	endtask

	// loads of 80, 00, 7F, each followed by a one-cycle filler opcode
	task test_load;
		logic [7:0] v;
		start_reset();
		mem.put(16'h0000, 32'hA6809DA6, 4);
		mem.put(16'h0004, 32'h009DA67F, 4);
		mem.put(16'h0008, 32'h9D000000, 1);
		release_reset(20);
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 8'h80 : ((i == 1) ? 8'h00 : 8'h7F);
			at_fetch(2, 16'(3 * i + 2));
			chk("accumulator", {8'h00, v}, {8'h00, accumulator});
			at_fetch(1, 16'(3 * i + 3));
			chk("flag_n", {15'h0000, v[7]}, {15'h0000, flag_n});
			chk("flag_z", {15'h0000, v == 8'h00}, {15'h0000, flag_z});
		end
		$display("test load done");
	endtask

	task test_store;
		start_reset();
		mem.put(16'h0000, 32'hA65AB780, 4);
		release_reset(2);
		at_fetch(2, 16'h0002);
		step(3);
		chk("store address", 16'h0080, mem_addr);
		chk("store strobe", 16'h0001, {15'h0000, mem_we});
		chk("store data", 16'h005A, {8'h00, mem_wdata});
		at_fetch(1, 16'h0004);
		chk("stored byte", 16'h005A, {8'h00, mem.mem[16'h0080]});
		$display("test store done");
	endtask

	// call, count-down loop, return, then store of the result
	task test_call;
		start_reset();
		mem.put(16'h0000, 32'hA602CD02, 4);
		mem.put(16'h0004, 32'h00B78000, 3);
		mem.put(16'h0200, 32'h4A26FD81, 4);
		release_reset(2);
		at_fetch(2, 16'h0002);
		step(4);
		chk("push low address", 16'h00FF, mem_addr);
		chk("push low data", 16'h0005, {8'h00, mem_wdata});
		chk("push low strobe", 16'h0001, {15'h0000, mem_we});
		step(1);
		chk("push high address", 16'h00FE, mem_addr);
		chk("push high data", 16'h0000, {8'h00, mem_wdata});
		at_fetch(1, 16'h0200);
		chk("stack after call", 16'h00FD, {8'h00, stack_pointer});
		at_fetch(3, 16'h0201);
		at_fetch(3, 16'h0200);
		at_fetch(3, 16'h0201);
		at_fetch(3, 16'h0203);
		chk("accumulator", 16'h0000, {8'h00, accumulator});
		at_fetch(6, 16'h0005);
		chk("stack after return", 16'h00FF, {8'h00, stack_pointer});
		at_fetch(4, 16'h0007);
		chk("stored byte", 16'h0000, {8'h00, mem.mem[16'h0080]});
		$display("test call done");
	endtask

	task test_plus;
		start_reset();
		mem.put(16'h0000, 32'hA6802A02, 4);
		mem.put(16'h0004, 32'hA6012A7F, 4);
		release_reset(2);
		at_fetch(2, 16'h0002);
		at_fetch(3, 16'h0004);
		at_fetch(2, 16'h0006);
		at_fetch(3, 16'h0087);
		$display("test plus done");
	endtask

	task test_bits;
		start_reset();
		mem.put(16'h0000, 32'h0F801000, 3);
		mem.put(16'h0013, 32'h0F81F00E, 4);
		mem.put(16'h0017, 32'h81030000, 2);
		mem.put(16'h0080, 32'h7F800000, 2);
		release_reset(2);
		at_fetch(5, 16'h0013);
		at_fetch(5, 16'h0016);
		at_fetch(5, 16'h001C);
		$display("test bits done");
	endtask

	// equal, minus, short call, a never-taken 2x code and always
	task test_misc;
		start_reset();
		mem.put(16'h0000, 32'hA6002702, 4);
		mem.put(16'h0006, 32'h2B05AD10, 4);
		mem.put(16'h000A, 32'h210520FE, 4);
		mem.put(16'h001A, 32'h81000000, 1);
		release_reset(2);
		at_fetch(2, 16'h0002);
		at_fetch(3, 16'h0006);
		at_fetch(3, 16'h0008);
		at_fetch(5, 16'h001A);
		chk("short call stack", 16'h00FD, {8'h00, stack_pointer});
		chk("pushed low", 16'h000A, {8'h00, mem.mem[16'h00FF]});
		chk("pushed high", 16'h0000, {8'h00, mem.mem[16'h00FE]});
		at_fetch(6, 16'h000A);
		at_fetch(3, 16'h000C);
		at_fetch(3, 16'h000C);
		$display("test misc done");
	endtask

	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// the whole run is about 130 cycles
	initial begin
		#20000;
		error_cnt++;
		give_verdict();
	end

	initial begin
		rst = 1'b1;
		error_cnt = 0;
		n_compared = 0;
		test_load();
		test_store();
		test_call();
		test_plus();
		test_bits();
		test_misc();
		give_verdict();
	end
endmodule
